/* rtl/level_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module level_sync #(
	parameter int unsigned WIDTH = 2
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] async_i,
	output var  logic [WIDTH-1:0] sync_o
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta;
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					meta      <= 1'b0;
					sync_o[i] <= 1'b0;
				end else begin
					meta      <= async_i[i];
					sync_o[i] <= meta;
				end
			end
		end
	endgenerate

endmodule : level_sync

`default_nettype wire

/* rtl/power_fail_pkg.sv */
// Behaviour
// - Hold the core in reset while the supply sits below the reset threshold.
// - After supply recovery count 65,536 clocks, then release the core at 0000h.
// - Enabled early-warning supply drop requests an interrupt vectoring to 0033h.
// - Power-fail interrupt outranks every other source, high priority ones too.
// - Writing 1 to the enable bit enables the warning interrupt, 0 disables it.
// - Warning sets the power-fail flag regardless of enable; it stays until cleared.
// - Drive reset output low on external, watchdog, oscillator-fail or power-fail reset.
// - Long resets last 65,536 clocks, external under 1.25, watchdog 2 machine cycles.
// - Global interrupt enable does not gate the power-fail interrupt request.
// - Power-on flag writes count only in three-cycle window after AAh, 55h to C7h.
`default_nettype none

package power_fail_pkg;

	localparam int unsigned CLOCK_PERIOD_NS          = 5;
	localparam int unsigned POR_CYCLES               = 65536;
	localparam int unsigned CLOCKS_PER_MACHINE_CYCLE = 4;
	localparam int unsigned WDT_RESET_MACHINE_CYCLES = 2;
	localparam int unsigned WDT_RESET_CYCLES         = WDT_RESET_MACHINE_CYCLES * CLOCKS_PER_MACHINE_CYCLE;
	localparam int unsigned TA_WINDOW_CYCLES         = 3;

	localparam logic [7:0]  TA_ADDR            = 8'hC7;
	localparam logic [7:0]  TA_KEY_FIRST       = 8'hAA;
	localparam logic [7:0]  TA_KEY_SECOND      = 8'h55;
	localparam logic [15:0] RESET_VECTOR       = 16'h0000;
	localparam logic [15:0] WARNING_IRQ_VECTOR = 16'h0033;

	typedef enum logic [1:0] {
		ST_HOLD  = 2'b00,
		ST_LONG  = 2'b01,
		ST_RUN   = 2'b10,
		ST_SHORT = 2'b11
	} seq_state_e;

	typedef struct packed {
		logic ext;
		logic wdt;
		logic osc;
	} reset_req_s;

	typedef struct packed {
		logic        req;
		logic [15:0] vector;
	} irq_req_s;

	typedef struct packed {
		logic       write;
		logic [7:0] addr;
		logic [7:0] data;
	} sfr_write_s;

endpackage : power_fail_pkg

`default_nettype wire

/* rtl/power_fail_reset_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none

module power_fail_reset_sequencer #(
	parameter int unsigned POR_CYCLES = power_fail_pkg::POR_CYCLES
) (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	// Supply comparators, asynchronous
	input  wire logic                     supply_ok_i,
	input  wire logic                     supply_warning_i,
	// Reset sources from neighbouring blocks
	input  wire power_fail_pkg::reset_req_s reset_req_i,
	// Software control bits
	input  wire logic                     power_fail_irq_enable_write_i,
	input  wire logic                     power_fail_irq_enable_data_i,
	input  wire logic                     power_fail_flag_clear_i,
	input  wire power_fail_pkg::sfr_write_s sfr_write_i,
	input  wire logic                     power_on_flag_write_i,
	input  wire logic                     power_on_flag_data_i,
	// Other interrupt sources, already arbitrated
	input  wire power_fail_pkg::irq_req_s other_irq_i,
	input  wire logic                     global_irq_enable_i,
	// Core control
	output var  logic                     core_reset_o,
	output var  logic [15:0]              core_start_addr_o,
	output var  logic                     reset_output_low_n_o,
	// Interrupt request to the core
	output var  power_fail_pkg::irq_req_s irq_o,
	// Status bits
	output var  logic                     power_fail_irq_enable_o,
	output var  logic                     power_fail_warning_flag_o,
	output var  logic                     power_on_flag_o
);

	import power_fail_pkg::*;

	localparam int unsigned CNT_W     = $clog2(POR_CYCLES + 1);
	localparam int unsigned TA_W      = $clog2(TA_WINDOW_CYCLES + 1);
	localparam logic [CNT_W-1:0] LONG_LOAD  = CNT_W'(POR_CYCLES - 1);
	localparam logic [CNT_W-1:0] SHORT_LOAD = CNT_W'(WDT_RESET_CYCLES - 1);
	localparam logic [TA_W-1:0]  TA_LOAD    = TA_W'(TA_WINDOW_CYCLES);

	// Comparator levels cross in through two flops
	logic [1:0] comp_sync;
	level_sync #(
		.WIDTH (2)
	) u_comp_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.async_i ({supply_warning_i, supply_ok_i}),
		.sync_o  (comp_sync)
	);

	wire logic supply_ok      = comp_sync[0];
	wire logic supply_warning = comp_sync[1];

	// Sequencer state
	seq_state_e       state;
	seq_state_e       next_state;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic             next_por_event;

	always_comb begin
		next_state     = state;
		next_count     = count;
		next_por_event = 1'b0;
		case (state)
			ST_HOLD: begin
				if (supply_ok) begin
					next_state     = ST_LONG;
					next_count     = LONG_LOAD;
					next_por_event = 1'b1;
				end
			end
			ST_LONG: begin
				if (reset_req_i.osc) begin
					next_count = LONG_LOAD;
				end else if (count == '0) begin
					next_state = ST_RUN;
				end else begin
					next_count = count - 1'b1;
				end
			end
			ST_RUN: begin
				// Pulses come from logic on this clock, so no synchroniser
				if (reset_req_i.osc) begin
					next_state = ST_LONG;
					next_count = LONG_LOAD;
				end else if (reset_req_i.wdt) begin
					next_state = ST_SHORT;
					next_count = SHORT_LOAD;
				end else if (reset_req_i.ext) begin
					next_state = ST_SHORT;
					next_count = '0;
				end
			end
			ST_SHORT: begin
				if (reset_req_i.osc) begin
					next_state = ST_LONG;
					next_count = LONG_LOAD;
				end else if (reset_req_i.wdt) begin
					next_count = SHORT_LOAD;
				end else if (reset_req_i.ext) begin
					// External reset stretches nothing beyond its own level
					next_count = '0;
				end else if (count == '0) begin
					next_state = ST_RUN;
				end else begin
					next_count = count - 1'b1;
				end
			end
			default: begin
				next_state = ST_HOLD;
				next_count = '0;
			end
		endcase
		// Supply loss overrides every other source
		if (!supply_ok) begin
			next_state = ST_HOLD;
			next_count = '0;
		end
	end

	wire logic next_in_reset = (next_state != ST_RUN);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state                <= ST_HOLD;
			count                <= '0;
			core_reset_o         <= 1'b1;
			reset_output_low_n_o <= 1'b0;
			core_start_addr_o    <= RESET_VECTOR;
		end else begin
			state                <= next_state;
			count                <= next_count;
			core_reset_o         <= next_in_reset;
			reset_output_low_n_o <= !next_in_reset;
			core_start_addr_o    <= RESET_VECTOR;
		end
	end

	// Timed-access unlock sequence
	logic            ta_armed;
	logic [TA_W-1:0] ta_window;

	wire logic ta_hit        = sfr_write_i.write && (sfr_write_i.addr == TA_ADDR);
	wire logic ta_first      = ta_hit && (sfr_write_i.data == TA_KEY_FIRST);
	wire logic ta_second     = ta_hit && ta_armed && (sfr_write_i.data == TA_KEY_SECOND);
	wire logic ta_open       = (ta_window != '0);
	wire logic por_write_ok  = power_on_flag_write_i && ta_open;

	logic            next_ta_armed;
	logic [TA_W-1:0] next_ta_window;

	always_comb begin
		next_ta_armed  = ta_armed;
		next_ta_window = ta_window;
		if (ta_open) begin
			next_ta_window = ta_window - 1'b1;
		end
		if (sfr_write_i.write) begin
			// Any write between the two keys breaks the sequence
			next_ta_armed = ta_first;
		end
		if (ta_second) begin
			next_ta_window = TA_LOAD;
		end else if (por_write_ok) begin
			// One protected write per unlock
			next_ta_window = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ta_armed  <= 1'b0;
			ta_window <= '0;
		end else begin
			ta_armed  <= next_ta_armed;
			ta_window <= next_ta_window;
		end
	end

	// Power-on flag, hardware set wins over a protected write
	logic next_power_on_flag;
	assign next_power_on_flag = next_por_event ? 1'b1 :
	                            por_write_ok ? power_on_flag_data_i :
	                            power_on_flag_o;

	// Warning flag, sticky; a warning in the clear cycle keeps it set
	logic next_warning_flag;
	assign next_warning_flag = supply_warning ? 1'b1 :
	                           power_fail_flag_clear_i ? 1'b0 :
	                           power_fail_warning_flag_o;

	logic next_irq_enable;
	assign next_irq_enable = power_fail_irq_enable_write_i ? power_fail_irq_enable_data_i
	                                                       : power_fail_irq_enable_o;

	// Interrupt selection; the power-fail request skips the global enable
	wire logic pf_req    = next_irq_enable && next_warning_flag;
	wire logic other_req = other_irq_i.req && global_irq_enable_i;

	irq_req_s next_irq;
	assign next_irq.req    = pf_req || other_req;
	assign next_irq.vector = pf_req ? WARNING_IRQ_VECTOR :
	                         other_req ? other_irq_i.vector : 16'h0000;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			power_on_flag_o           <= 1'b0;
			power_fail_warning_flag_o <= 1'b0;
			power_fail_irq_enable_o   <= 1'b0;
			irq_o                     <= '0;
		end else begin
			power_on_flag_o           <= next_power_on_flag;
			power_fail_warning_flag_o <= next_warning_flag;
			power_fail_irq_enable_o   <= next_irq_enable;
			irq_o                     <= next_irq;
		end
	end

endmodule : power_fail_reset_sequencer

`default_nettype wire

/* sim/far_side_model.sv */
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
	// Clock
	input  wire logic                       clk_i,
	// Requests towards the sequencer
	output var  power_fail_pkg::reset_req_s reset_req_o,
	output var  power_fail_pkg::sfr_write_s sfr_o
);
	import power_fail_pkg::*;
	initial begin
		reset_req_o = '0;
		sfr_o = '0;
	end
	// Watchdog and oscillator callers use n = 1 only
	task automatic pulse(input logic [2:0] which, input int n);
		@(posedge clk_i);
		#1 reset_req_o = which;
		repeat (n) @(posedge clk_i);
		#1 reset_req_o = '0;
	endtask : pulse
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1 sfr_o = {1'b1, a, d};
		@(posedge clk_i);
		#1 sfr_o = '0;
	endtask : wr
	task automatic unlock;
		wr(8'hC7, 8'hAA);
		wr(8'hC7, 8'h55);
	endtask : unlock
endmodule : far_side_model
`default_nettype wire

/* sim/power_fail_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module power_fail_checker (
	// Inputs of the sequencer
	input wire logic                       clk_i,
	input wire logic                       reset_i,
	input wire logic                       supply_ok_i,
	input wire logic                       supply_warning_i,
	input wire power_fail_pkg::reset_req_s reset_req_i,
	input wire logic                       power_fail_irq_enable_write_i,
	input wire logic                       power_fail_irq_enable_data_i,
	input wire logic                       power_fail_flag_clear_i,
	// Outputs of the sequencer
	input wire logic                       core_reset_o,
	input wire logic [15:0]                core_start_addr_o,
	input wire logic                       reset_output_low_n_o,
	input wire power_fail_pkg::irq_req_s   irq_o,
	input wire logic                       power_fail_irq_enable_o,
	input wire logic                       power_fail_warning_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Eight cycles of watchdog reset, then release
	sequence wdt_hold;
		core_reset_o[*8] ##1 !core_reset_o;
	endsequence
	// Three low samples cover the two sync flops
	a_hold_low_supply: assert property (!supply_ok_i[*3] |=> core_reset_o)
		else $error("core runs on low supply");
	a_pin_follows: assert property (reset_output_low_n_o == !core_reset_o)
		else $error("reset pin disagrees with core reset");
	a_start_vector: assert property (core_start_addr_o == 16'h0000)
		else $error("start address wrong");
	a_wdt_length: assert property (!core_reset_o && reset_req_i.wdt && !reset_req_i.osc && supply_ok_i |=> wdt_hold)
		else $error("watchdog reset length wrong");
	a_power_fail_wins: assert property (power_fail_irq_enable_o && power_fail_warning_flag_o
		|-> irq_o.req && irq_o.vector == 16'h0033)
		else $error("power-fail request missing or lost");
	a_flag_sets: assert property (supply_warning_i[*3] |=> power_fail_warning_flag_o)
		else $error("warning flag not set");
	a_flag_sticky: assert property (power_fail_warning_flag_o && !power_fail_flag_clear_i |=> power_fail_warning_flag_o)
		else $error("warning flag dropped");
	a_enable_load: assert property (power_fail_irq_enable_write_i
		|=> power_fail_irq_enable_o == $past(power_fail_irq_enable_data_i))
		else $error("enable bit not loaded");
endmodule : power_fail_checker
bind power_fail_reset_sequencer power_fail_checker power_fail_checker_i (.clk_i(clk_i), .reset_i(reset_i),
	.supply_ok_i(supply_ok_i), .supply_warning_i(supply_warning_i), .reset_req_i(reset_req_i),
	.power_fail_irq_enable_write_i(power_fail_irq_enable_write_i),
	.power_fail_irq_enable_data_i(power_fail_irq_enable_data_i),
	.power_fail_flag_clear_i(power_fail_flag_clear_i), .core_reset_o(core_reset_o),
	.core_start_addr_o(core_start_addr_o), .reset_output_low_n_o(reset_output_low_n_o), .irq_o(irq_o),
	.power_fail_irq_enable_o(power_fail_irq_enable_o), .power_fail_warning_flag_o(power_fail_warning_flag_o));
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import power_fail_pkg::*;
	localparam int unsigned POR = 16;
	logic clk, rst, ok, warn, en_wr, en_d, clr, por_wr, por_d, gie, core_rst, rst_n, pfe, pff, pof;
	logic [15:0] start;
	irq_req_s other, irq;
	reset_req_s req;
	sfr_write_s sfr;
	int err_count = 0;
	int check_count = 0;
	power_fail_reset_sequencer #(.POR_CYCLES(POR)) power_fail_reset_sequencer_i (.clk_i(clk), .reset_i(rst),
		.supply_ok_i(ok), .supply_warning_i(warn), .reset_req_i(req), .power_fail_irq_enable_write_i(en_wr),
		.power_fail_irq_enable_data_i(en_d), .power_fail_flag_clear_i(clr), .sfr_write_i(sfr),
		.power_on_flag_write_i(por_wr), .power_on_flag_data_i(por_d), .other_irq_i(other),
		.global_irq_enable_i(gie), .core_reset_o(core_rst), .core_start_addr_o(start),
		.reset_output_low_n_o(rst_n), .irq_o(irq), .power_fail_irq_enable_o(pfe),
		.power_fail_warning_flag_o(pff), .power_on_flag_o(pof));
	far_side_model far_side_model_i (.clk_i(clk), .reset_req_o(req), .sfr_o(sfr));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	// Bounded wait; a hang is counted and ends the run
	task automatic hi_len(output int n);
		n = 0;
		while (core_rst === 1'b1 && n < 1000) begin
			step(1);
			n++;
		end
		if (n >= 1000) begin
			err_count++;
			finish_test();
		end
	endtask : hi_len
	task automatic t_supply_up;
		int n;
		step(10);
		chk(core_rst, 1, "held low supply");
		ok = 1;
		hi_len(n);
		chk(n, POR + 3, "long reset");
		chk(start, 16'h0000, "start");
		chk(pof, 1, "por flag");
	endtask : t_supply_up
	task automatic por_write(input logic d, input int gap);
		if (gap > 0)
			step(gap);
		{por_wr, por_d} = {1'b1, d};
		step(1);
		por_wr = 0;
	endtask : por_write
	task automatic t_timed;
		por_write(0, 1);
		chk(pof, 1, "unarmed write");
		far_side_model_i.unlock();
		por_write(0, 3);
		chk(pof, 1, "late write");
		far_side_model_i.unlock();
		por_write(0, 0);
		chk(pof, 0, "window write");
	endtask : t_timed
	task automatic t_resets;
		int n;
		far_side_model_i.pulse(3'b010, 1);
		hi_len(n);
		chk(n, 8, "watchdog");
		far_side_model_i.pulse(3'b100, 3);
		hi_len(n);
		chk(n, 1, "external tail");
		far_side_model_i.pulse(3'b001, 1);
		hi_len(n);
		chk(n, POR, "osc reset");
	endtask : t_resets
	task automatic t_pfi;
		warn = 1;
		step(4);
		chk(pff, 1, "flag while disabled");
		chk(irq.req, 0, "masked");
		{en_wr, en_d} = 2'b11;
		step(1);
		en_wr = 0;
		chk(pfe, 1, "enable set");
		chk(irq.req, 1, "power-fail request without global enable");
		chk(irq.vector, 16'h0033, "power-fail vector");
		gie = 1;
		step(1);
		chk(irq.vector, 16'h0033, "power-fail priority");
		{en_wr, en_d} = 2'b10;
		step(1);
		en_wr = 0;
		chk(pfe, 0, "enable cleared");
		chk(irq.vector, 16'h0003, "power-fail request disabled");
		warn = 0;
		step(4);
		chk(pff, 1, "sticky");
		clr = 1;
		step(1);
		clr = 0;
		step(1);
		chk(pff, 0, "cleared");
	endtask : t_pfi
	task automatic t_supply_drop;
		ok = 0;
		step(3);
		chk(rst_n, 0, "power fail pin");
		t_supply_up();
	endtask : t_supply_drop
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		{rst, ok, warn, en_wr, en_d, clr, por_wr, por_d, gie} = 9'h100;
		other = {1'b1, 16'h0003};
		step(4);
		rst = 0;
		t_supply_up();
		t_timed();
		t_resets();
		t_pfi();
		t_supply_drop();
		finish_test();
	end
endmodule : tb
`default_nettype wire
